// File: src/sample_port_pkg.sv
// Summary of operation
// - Sample input on every rising clock edge while not in power-down
// - Output enable low drives all twelve pins
// - Output enable high floats all twelve pins
// - Sleep request high enters power-down mode
// - Sleep request low converts samples normally
// - Twelve-bit offset binary, bit 0 least significant
// - One complete word per sample, sustained
package sample_port_pkg;
	// Word width of a conversion result
	localparam int WORD_W = 12;
	// Default pipeline latency in clock cycles
	localparam int LATENCY_CYC = 6;
	// Conversion clock limits and nominal rate, in kHz
	localparam int CLK_MIN_KHZ = 100;
	localparam int CLK_MAX_KHZ = 30000;
	localparam int CLK_NOM_KHZ = 20000;
	// Value shown on the bus after reset: all lines low
	localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
	// Offset binary code for zero input
	localparam logic [WORD_W-1:0] MID_SCALE = 12'h800;

	// One pipeline stage: a result and its valid mark
	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] word;
	} stage_t;

	// Bus pins as two vectors: line levels and per-line drive enables
	typedef struct packed {
		logic [WORD_W-1:0] out;
		logic [WORD_W-1:0] oe;
	} pin_bus_t;

	// Power modes
	typedef enum logic [0:0] {
		MODE_ACTIVE = 1'b0,
		MODE_SLEEP = 1'b1
	} mode_t;
endpackage

// File: src/sample_pipe.sv
`timescale 1ns/1ps
// Fixed-latency delay line for conversion results
module sample_pipe #(
	parameter int DEPTH = sample_port_pkg::LATENCY_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Stage input and output
	input wire sample_port_pkg::stage_t din,
	output sample_port_pkg::stage_t dout
);
	import sample_port_pkg::*;

	// Stage storage, indexed
	stage_t pipe [DEPTH];
	stage_t next_pipe [DEPTH];

	// Shift every stage by one each clock
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			if (i == 0) begin
				next_pipe[i] = din;
			end else begin
				next_pipe[i] = pipe[i-1];
			end
		end
	end

	// Register the stages
	always_ff @(posedge mclk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (!rst_n) begin
				pipe[i] <= '{valid: 1'b0, word: WORD_RESET};
			end else begin
				pipe[i] <= next_pipe[i];
			end
		end
	end

	// Oldest stage leaves the line
	assign dout = pipe[DEPTH-1];
endmodule // sample_pipe

// File: src/adc_parallel_sample_port.sv
`timescale 1ns/1ps
// Digital side of the sampling converter: capture, pipeline, bus drive
module adc_parallel_sample_port #(
	parameter int LATENCY = sample_port_pkg::LATENCY_CYC
) (
	// Conversion clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Quantiser result sampled each edge while active, offset binary
	input wire logic [sample_port_pkg::WORD_W-1:0] quant_code,
	// Control pins from the capture party
	input wire logic output_enable_n,
	input wire logic sleep_request,
	// Parallel data bus
	output logic [sample_port_pkg::WORD_W-1:0] sample_word_out,
	output logic [sample_port_pkg::WORD_W-1:0] sample_word_oe,
	// Power state and result mark
	output logic power_down,
	output logic sample_valid
);
	import sample_port_pkg::*;

	// Synchronisers for the pin inputs
	logic oe_n_meta, oe_n_sync;
	logic sleep_meta, sleep_sync;
	// Power mode state
	mode_t mode, next_mode;
	// Capture stage and pipeline tail
	stage_t cap, next_cap;
	stage_t tail;
	// Registered bus drive
	pin_bus_t bus, next_bus;

	// Two-flop synchronisers; first flop feeds only the second
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			oe_n_meta <= 1'b1;
			oe_n_sync <= 1'b1;
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end else begin
			oe_n_meta <= output_enable_n;
			oe_n_sync <= oe_n_meta;
			sleep_meta <= sleep_request;
			sleep_sync <= sleep_meta;
		end
	end

	// Mode follows the synchronised sleep request
	// Two flops ahead of it keep a metastable pin out of the mode
	always_comb begin
		next_mode = sleep_sync ? MODE_SLEEP : MODE_ACTIVE;
	end

	// Capture one new sample per edge while active
	always_comb begin
		next_cap = cap;
		unique case (mode)
			// A fresh word every edge keeps the full conversion rate
			MODE_ACTIVE: begin
				next_cap = '{valid: 1'b1, word: quant_code};
			end
			// Keep the old word but mark it stale so nothing new leaves
			MODE_SLEEP: begin
				next_cap = '{valid: 1'b0, word: cap.word};
			end
		endcase
	end

	// Register mode and capture
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode <= MODE_ACTIVE;
			cap <= '{valid: 1'b0, word: WORD_RESET};
		end else begin
			mode <= next_mode;
			cap <= next_cap;
		end
	end

	// Fixed-latency pipeline after capture
	sample_pipe #(
		.DEPTH(LATENCY)
	) u_pipe (
		.mclk(mclk),
		.rst_n(rst_n),
		.din(cap),
		.dout(tail)
	);

	// Bus drive: word held until a new valid result, enable per bit
	always_comb begin
		// A drained pipe shows no valid word, so the bus keeps its level
		next_bus.out = tail.valid ? tail.word : bus.out;
		// All twelve pins share the one synchronised enable
		for (int b = 0; b < WORD_W; b++) begin
			next_bus.oe[b] = !oe_n_sync;
		end
	end

	// Register bus drive
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus <= '{out: WORD_RESET, oe: '0};
		end else begin
			bus <= next_bus;
		end
	end

	// Pins and power state come straight from registers
	assign sample_word_out = bus.out;
	assign sample_word_oe = bus.oe;
	assign power_down = (mode == MODE_SLEEP);
	// Tail valid marks a fresh word one edge before the bus shows it
	assign sample_valid = tail.valid;

	// Assertions, all on mclk and idle while reset is held
	// The capture check reads rst_n as sampled, so the edge that
	// releases reset opens no attempt that would still see reset values
	property p_float_when_disabled;
		@(posedge mclk) disable iff (!rst_n)
		$past(oe_n_sync) |-> (sample_word_oe == '0);
	endproperty
	a_float_when_disabled: assert property (p_float_when_disabled)
		else $error("bus driven while output enable high");

	property p_drive_when_enabled;
		@(posedge mclk) disable iff (!rst_n)
		(!output_enable_n [*4]) |-> (sample_word_oe == '1);
	endproperty
	a_drive_when_enabled: assert property (p_drive_when_enabled)
		else $error("bus not driven while output enable low");

	property p_sleep_enters;
		@(posedge mclk) disable iff (!rst_n)
		(sleep_request [*4]) |-> power_down;
	endproperty
	a_sleep_enters: assert property (p_sleep_enters)
		else $error("no power-down after sleep request");

	property p_wake;
		@(posedge mclk) disable iff (!rst_n)
		(!sleep_request [*4]) |-> !power_down;
	endproperty
	a_wake: assert property (p_wake)
		else $error("still in power-down after release");

	property p_sample_each_edge;
		@(posedge mclk) disable iff (!rst_n)
		(rst_n && !power_down && !$past(power_down))
			|=> (cap.valid && cap.word == $past(quant_code));
	endproperty
	a_sample_each_edge: assert property (p_sample_each_edge)
		else $error("sample not taken on active edge");

	property p_latency;
		@(posedge mclk) disable iff (!rst_n)
		cap.valid |-> ##(LATENCY) (tail.valid && tail.word == $past(cap.word, LATENCY));
	endproperty
	a_latency: assert property (p_latency)
		else $error("result latency wrong");

	property p_word_on_bus;
		@(posedge mclk) disable iff (!rst_n)
		tail.valid |=> (sample_word_out == $past(tail.word));
	endproperty
	a_word_on_bus: assert property (p_word_on_bus)
		else $error("result not presented on bus");

	property p_sustained;
		@(posedge mclk) disable iff (!rst_n)
		(cap.valid [*8]) |-> ##(LATENCY) (sample_valid
			&& $past(sample_valid, 1) && $past(sample_valid, 2)
			&& $past(sample_valid, 3) && $past(sample_valid, 4)
			&& $past(sample_valid, 5) && $past(sample_valid, 6)
			&& $past(sample_valid, 7));
	endproperty
	a_sustained: assert property (p_sustained)
		else $error("word rate not sustained");

	property p_no_capture_in_sleep;
		@(posedge mclk) disable iff (!rst_n)
		power_down |=> !cap.valid;
	endproperty
	a_no_capture_in_sleep: assert property (p_no_capture_in_sleep)
		else $error("sample taken during power-down");

	property p_word_holds;
		@(posedge mclk) disable iff (!rst_n)
		!sample_valid |=> $stable(sample_word_out);
	endproperty
	a_word_holds: assert property (p_word_holds)
		else $error("bus word changed without a new result");

	property p_pins_together;
		@(posedge mclk) disable iff (!rst_n)
		(sample_word_oe == '0) || (sample_word_oe == '1);
	endproperty
	a_pins_together: assert property (p_pins_together)
		else $error("bus pins enabled unevenly");

	property p_wake_resumes;
		@(posedge mclk) disable iff (!rst_n)
		(!power_down && $past(power_down)) |=> cap.valid;
	endproperty
	a_wake_resumes: assert property (p_wake_resumes)
		else $error("capture not resumed after wake");

	property p_valid_from_active;
		@(posedge mclk) disable iff (!rst_n)
		sample_valid |-> !$past(power_down, LATENCY + 1);
	endproperty
	a_valid_from_active: assert property (p_valid_from_active)
		else $error("result emitted from a sleeping sample");

	property p_mode_follows;
		@(posedge mclk) disable iff (!rst_n)
		power_down == $past(sleep_sync);
	endproperty
	a_mode_follows: assert property (p_mode_follows)
		else $error("power state does not follow sleep request");
endmodule // adc_parallel_sample_port

// File: bench/capture_model.sv
`timescale 1ns/1ps
// Capture side: resolves the shared data bus seen at its pins
module capture_model (
	// Clock
	input wire logic mclk,
	// Device bus drive
	input wire logic [sample_port_pkg::WORD_W-1:0] word_out,
	input wire logic [sample_port_pkg::WORD_W-1:0] word_oe,
	// Resolved bus level
	output logic [sample_port_pkg::WORD_W-1:0] bus
);
	import sample_port_pkg::*;
	logic [WORD_W-1:0] last = 12'h000; // Last level per line
	// A floated line has no pull: it flips each cycle
	always_comb begin
		for (int i = 0; i < WORD_W; i++) begin
			bus[i] = word_oe[i] ? word_out[i] : ~last[i];
		end
	end
	// Remember the levels
	always_ff @(posedge mclk) begin
		last <= bus;
	end
endmodule // capture_model

// File: bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the parallel sample port
module testbench;
	import sample_port_pkg::*;
	localparam int LAT = 3; // Short pipeline
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [WORD_W-1:0] quant_code = 12'h000;
	logic output_enable_n = 1'b1;
	logic sleep_request = 1'b0;
	logic [WORD_W-1:0] word_out, word_oe, bus;
	logic power_down, sample_valid;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	// Device and capture side
	adc_parallel_sample_port #(.LATENCY(LAT)) dut (.mclk(mclk), .rst_n(rst_n),
		.quant_code(quant_code), .output_enable_n(output_enable_n),
		.sleep_request(sleep_request), .sample_word_out(word_out),
		.sample_word_oe(word_oe), .power_down(power_down), .sample_valid(sample_valid));
	capture_model cap (.mclk(mclk), .word_out(word_out), .word_oe(word_oe), .bus(bus));
	// Conversion clock from the capture side
	initial forever #5 mclk = ~mclk;
	task automatic check(string name, logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Enable drives all lines after the sync delay
	task automatic enable_test();
		@(posedge mclk);
		output_enable_n <= 1'b0;
		tick(2);
		check("oe early", word_oe, 12'h000);
		tick(1);
		check("oe", word_oe, 12'hFFF);
	endtask
	// Walking one then all ones, back to back, each after the fixed delay
	task automatic stream_test();
		logic [WORD_W-1:0] v [13];
		for (int i = 0; i < 13; i++) v[i] = (i == 12) ? 12'hFFF : 12'h001 << i;
		for (int j = 0; j < 13 + LAT + 2; j++) begin
			@(posedge mclk);
			if (j < 13) quant_code <= v[j];
			#1;
			if (j >= LAT + 2) begin
				check("word", word_out, v[j-LAT-2]);
				check("bus", bus, v[j-LAT-2]);
				check("valid", {11'h0, sample_valid}, 12'h001);
			end
		end
	endtask
	// Sleep halts capture and keeps the last word; wake resumes
	task automatic sleep_test();
		@(posedge mclk);
		sleep_request <= 1'b1;
		tick(2);
		check("pd early", {11'h0, power_down}, 12'h000);
		tick(1);
		check("pd", {11'h0, power_down}, 12'h001);
		@(posedge mclk);
		quant_code <= 12'h5A5;
		tick(LAT + 3);
		check("valid", {11'h0, sample_valid}, 12'h000);
		check("held", word_out, 12'hFFF);
		@(posedge mclk);
		sleep_request <= 1'b0;
		tick(3);
		check("pd", {11'h0, power_down}, 12'h000);
		tick(LAT + 2);
		check("wake", word_out, 12'h5A5);
		@(posedge mclk);
		output_enable_n <= 1'b1;
		tick(2);
		check("oe late", word_oe, 12'hFFF);
		tick(1);
		check("oe off", word_oe, 12'h000);
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		tick(1);
		check("rst oe", word_oe, 12'h000);
		check("rst word", word_out, WORD_RESET);
		enable_test();
		stream_test();
		sleep_test();
		close_out();
	end
endmodule // testbench
